// File: pkg/mrc_consts.svh
// reset control constants: offsets, fields, reset values, timing counts
// assumes a 20 MHz system clock and a 32-bit apb register bus
`ifndef MRC_CONSTS_SVH
`define MRC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MRC_OFF_CAUSE 12'h000
`define MRC_OFF_WDOG_CTRL 12'h004
`define MRC_OFF_STATUS 12'h008
`define MRC_OFF_CORE 12'h00C

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define MRC_CAUSE_WDCTRL_BIT 0
`define MRC_CAUSE_BROWNOUT_BIT 2
`define MRC_STATUS_PDF_BIT 0
`define MRC_STATUS_TO_BIT 1
`define MRC_STATUS_MODE_LSB 4
`define MRC_WDOG_EN_LSB 3
`define MRC_WDOG_EN_PAT_A 5'h0A
`define MRC_WDOG_EN_PAT_B 5'h15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MRC_WDOG_CTRL_RST 8'h53
`define MRC_PORT_RST 8'hFF
`define MRC_PC_RST 12'h000
`define MRC_SP_RST 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MRC_CLK_NS 50
`define MRC_POR_DELAY_NS 1000
`define MRC_BROWNOUT_FILTER_NS 120000
`define MRC_SOFT_RESET_DELAY_NS 45000
`define MRC_POR_CYCLES ((`MRC_POR_DELAY_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS)
`define MRC_BROWNOUT_CYCLES (`MRC_BROWNOUT_FILTER_NS / `MRC_CLK_NS)
`define MRC_SOFT_RESET_CYCLES ((`MRC_SOFT_RESET_DELAY_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS)

`endif

// File: pkg/mrc_pkg.sv
// types of the reset control block
// assumes mrc_consts.svh for numeric constants
package mrc_pkg;

   // operating modes reported by the core
   typedef enum logic [1:0] {
      MRC_MODE_FAST  = 2'h0,
      MRC_MODE_SLOW  = 2'h1,
      MRC_MODE_IDLE  = 2'h2,
      MRC_MODE_SLEEP = 2'h3
   } mrc_mode_e;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      MRC_ST_HOLD   = 4'h1,
      MRC_ST_RUN    = 4'h2,
      MRC_ST_SOFT   = 4'h4,
      MRC_ST_WARM   = 4'h8
   } mrc_state_e;

   typedef logic [7:0] mrc_byte_t;

endpackage

// File: core/mrc_filter.sv
// persistence filter: output pulses once an input level has held long enough
// assumes input synchronous to clk
`timescale 1ns/1ps
`include "mrc_consts.svh"

module mrc_filter import mrc_pkg::*; #(
   parameter int CYCLES = 2400,
   parameter int CW = 16
) (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic enable,
   // level in, pulse out
   input wire logic level,
   output logic fired
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic fired_r;
   logic fired_nxt;

   // a dropped level restarts the count so short dips never add up
   always_comb begin
      cnt_nxt = cnt_r;
      fired_nxt = 1'b0;
      if (!enable || !level) begin
         cnt_nxt = '0;
      end else if (cnt_r == CW'(CYCLES)) begin
         fired_nxt = 1'b1;
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         fired_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         fired_r <= fired_nxt;
      end
   end

   assign fired = fired_r;

endmodule

// File: core/mrc_delay.sv
// one-shot delay: start pulse, done pulse after CYCLES cycles
// assumes start synchronous to clk
`timescale 1ns/1ps
`include "mrc_consts.svh"

module mrc_delay import mrc_pkg::*; #(
   parameter int CYCLES = 900,
   parameter int CW = 16
) (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // trigger
   input wire logic start,
   output logic busy,
   output logic done
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic run_r;
   logic run_nxt;
   logic done_r;
   logic done_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      done_nxt = 1'b0;
      if (run_r) begin
         if (cnt_r == CW'(CYCLES - 1)) begin
            run_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end else if (start) begin
         run_nxt = 1'b1;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = run_r;
   assign done = done_r;

endmodule

// File: core/mrc_reset_ctrl.sv
// reset control: combines power-on, brownout and watchdog resets
// assumes core status inputs synchronous to clk; rst is the power-on event
//
// Behaviour
// RULE_01: after power-on, hold internal reset for a short delay, then release
// RULE_02: power-on reset loads program counter with zero
// RULE_03: power-on reset sets port data and direction to all ones
// RULE_04: brownout detector active in fast and slow modes
// RULE_05: brownout detector off automatically in sleep and idle
// RULE_06: low supply resets only if longer than filter time
// RULE_07: valid brownout sets cause bit 2 and resets the device
// RULE_08: brownout flag set only by brownout, cleared only by software; a software write of 1 also sets it here
// RULE_09: watchdog-control flag bit 0 set by soft reset, software clears, zero at power-on
// RULE_10: cause bits 7..3 and bit 1 read zero
// RULE_11: normal-mode watchdog expiry: full reset, expiry flag set, power-down unchanged
// RULE_12: low-power expiry: clear pc and sp only, set both flags
// RULE_13: power-on clears both flags; brownout leaves them unchanged
// RULE_14: after reset every interrupt source disabled
// RULE_15: after reset clear watchdog and time-bases, watchdog restarts
// RULE_16: after reset all timer modules off
// RULE_17: after reset stack pointer indicates top of stack
// RULE_18: bad watchdog enable pattern resets after soft delay, sets flag
// RULE_19: all sources form one reset released synchronously to clk
// RULE_20: cause flags kept outside the reset they record
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "mrc_consts.svh"

module mrc_reset_ctrl import mrc_pkg::*; #(
   parameter int POR_CYCLES = `MRC_POR_CYCLES,
   parameter int BROWNOUT_CYCLES = `MRC_BROWNOUT_CYCLES,
   parameter int SOFT_CYCLES = `MRC_SOFT_RESET_CYCLES
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core and supply status
   input wire logic [1:0] op_mode,
   input wire logic low_supply,
   input wire logic wdog_timeout,
   input wire logic wdog_clear,
   input wire logic halt_entry,
   // reset outputs to the core
   output logic core_reset,
   output logic warm_reset,
   output logic [7:0] port_data_init,
   output logic [7:0] port_dir_init,
   output logic [11:0] pc_init,
   output logic [2:0] sp_init,
   output logic irq_disable,
   output logic timers_off,
   output logic wdog_count_clear
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic en_pattern_ok(input logic [4:0] en);
      return (en == `MRC_WDOG_EN_PAT_A) || (en == `MRC_WDOG_EN_PAT_B);
   endfunction

   function automatic logic low_power(input logic [1:0] m);
      return (m == MRC_MODE_IDLE) || (m == MRC_MODE_SLEEP);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   mrc_state_e st_r, st_nxt;
   logic [15:0] hold_r, hold_nxt;
   mrc_byte_t wdctl_r, wdctl_nxt;
   // flags below are never cleared by core_reset; rst clears all but the brownout flag [RULE_20]
   logic brown_flag_r, brown_flag_nxt;
   logic wdc_flag_r, wdc_flag_nxt;
   logic to_flag_r, to_flag_nxt;
   logic pdf_flag_r, pdf_flag_nxt;
   logic soft_start;
   logic soft_busy;
   logic soft_done;
   logic brown_fire;
   logic brown_en;
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == `MRC_OFF_CAUSE) || (paddr == `MRC_OFF_WDOG_CTRL) ||
                    (paddr == `MRC_OFF_STATUS) || (paddr == `MRC_OFF_CORE);

   assign brown_en = !low_power(op_mode);  // [RULE_04] [RULE_05]

   mrc_filter #(
      .CYCLES(BROWNOUT_CYCLES),
      .CW(16)
   ) i_mrc_filter (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .enable(brown_en),
      .level(low_supply),
      .fired(brown_fire)
   );  // [RULE_06]

   mrc_delay #(
      .CYCLES(SOFT_CYCLES),
      .CW(16)
   ) i_mrc_delay (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(soft_start),
      .busy(soft_busy),
      .done(soft_done)
   );

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // only the run state launches a soft reset so a delay never restarts itself;
   // a higher-priority source in the same cycle wins, else a stray flag would follow
   assign soft_start = (st_r == MRC_ST_RUN) && !soft_busy && !brown_fire && !wdog_timeout &&
                       !en_pattern_ok(wdctl_r[7:3]);  // [RULE_18]

   always_comb begin
      st_nxt = st_r;
      hold_nxt = hold_r;
      case (st_r)
         MRC_ST_HOLD: begin
            if (hold_r == 16'(POR_CYCLES - 1)) begin
               st_nxt = MRC_ST_RUN;  // [RULE_01] [RULE_19]
            end else begin
               hold_nxt = hold_r + 16'h0001;
            end
         end
         MRC_ST_RUN: begin
            if (brown_fire) begin
               st_nxt = MRC_ST_HOLD;
               hold_nxt = '0;
            end else if (wdog_timeout && low_power(op_mode)) begin
               st_nxt = MRC_ST_WARM;  // [RULE_12]
            end else if (wdog_timeout) begin
               st_nxt = MRC_ST_HOLD;  // [RULE_11]
               hold_nxt = '0;
            end else if (soft_start) begin
               st_nxt = MRC_ST_SOFT;
            end
         end
         MRC_ST_SOFT: begin
            if (soft_done) begin
               st_nxt = MRC_ST_HOLD;  // [RULE_18]
               hold_nxt = '0;
            end
         end
         MRC_ST_WARM: begin
            st_nxt = MRC_ST_RUN;
         end
         default: begin
            st_nxt = MRC_ST_HOLD;
            hold_nxt = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers and flags
   // ----------------------------------------------------------------
   always_comb begin
      wdctl_nxt = wdctl_r;
      brown_flag_nxt = brown_flag_r;
      wdc_flag_nxt = wdc_flag_r;
      to_flag_nxt = to_flag_r;
      pdf_flag_nxt = pdf_flag_r;
      if (wr_en && paddr == `MRC_OFF_WDOG_CTRL) begin
         wdctl_nxt = pwdata[7:0];
      end
      if (wr_en && paddr == `MRC_OFF_CAUSE) begin
         brown_flag_nxt = pwdata[`MRC_CAUSE_BROWNOUT_BIT];
         wdc_flag_nxt = pwdata[`MRC_CAUSE_WDCTRL_BIT];
      end
      if (wdog_clear) begin
         pdf_flag_nxt = 1'b0;
         to_flag_nxt = 1'b0;
      end
      if (halt_entry) begin
         pdf_flag_nxt = 1'b1;
      end
      // hardware sets win over a software clear in the same cycle
      if (st_r == MRC_ST_RUN && brown_fire) begin
         brown_flag_nxt = 1'b1;  // [RULE_07] [RULE_08] [RULE_13]
      end
      if (soft_done) begin
         wdc_flag_nxt = 1'b1;  // [RULE_09] [RULE_18]
      end
      if (st_r == MRC_ST_RUN && !brown_fire && wdog_timeout) begin
         to_flag_nxt = 1'b1;  // [RULE_11] [RULE_12]
         if (low_power(op_mode)) begin
            pdf_flag_nxt = 1'b1;  // [RULE_12]
         end
      end
      // full resets restore the control register default
      if (st_r == MRC_ST_HOLD) begin
         wdctl_nxt = `MRC_WDOG_CTRL_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= MRC_ST_HOLD;
         hold_r <= '0;
         wdctl_r <= `MRC_WDOG_CTRL_RST;
         wdc_flag_r <= 1'b0;  // [RULE_09]
         to_flag_r <= 1'b0;  // [RULE_13]
         pdf_flag_r <= 1'b0;  // [RULE_13]
      end else if (ce) begin
         st_r <= st_nxt;
         hold_r <= hold_nxt;
         wdctl_r <= wdctl_nxt;
         wdc_flag_r <= wdc_flag_nxt;
         to_flag_r <= to_flag_nxt;
         pdf_flag_r <= pdf_flag_nxt;
      end
   end

   // power-on value of the brownout flag is undefined; no reset term
   always_ff @(posedge clk) begin
      if (ce) begin
         brown_flag_r <= brown_flag_nxt;  // [RULE_08]
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      prdata = 32'h00000000;
      if (rd_en) begin
         case (paddr)
            `MRC_OFF_CAUSE: begin
               prdata[`MRC_CAUSE_BROWNOUT_BIT] = brown_flag_r;  // [RULE_10]
               prdata[`MRC_CAUSE_WDCTRL_BIT] = wdc_flag_r;
            end
            `MRC_OFF_WDOG_CTRL: prdata[7:0] = wdctl_r;
            `MRC_OFF_STATUS: begin
               prdata[`MRC_STATUS_PDF_BIT] = pdf_flag_r;
               prdata[`MRC_STATUS_TO_BIT] = to_flag_r;
               prdata[`MRC_STATUS_MODE_LSB +: 4] = st_r;
            end
            `MRC_OFF_CORE: prdata[0] = core_reset;
            default: prdata = 32'h00000000;
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // one synchronous reset for the whole core [RULE_19]
   assign core_reset = (st_r == MRC_ST_HOLD);
   assign warm_reset = (st_r == MRC_ST_WARM);  // [RULE_12]
   assign port_data_init = `MRC_PORT_RST;  // [RULE_03]
   assign port_dir_init = `MRC_PORT_RST;  // [RULE_03]
   assign pc_init = `MRC_PC_RST;  // [RULE_02]
   assign sp_init = `MRC_SP_RST;  // [RULE_17]
   assign irq_disable = core_reset;  // [RULE_14]
   assign timers_off = core_reset;  // [RULE_16]
   assign wdog_count_clear = core_reset || warm_reset;  // [RULE_15]

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence soft_launch_s;
      st_r == MRC_ST_RUN && soft_start && !brown_fire && !wdog_timeout;
   endsequence

   por_release_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_01]
      $fell(core_reset) |-> $past(hold_r) == 16'(POR_CYCLES - 1))
      else $error("core reset released outside hold");
   brown_flag_set_a: assert property (@(posedge clk) disable iff (rst || !ce)  // [RULE_07]
      (st_r == MRC_ST_RUN && brown_fire) |=> brown_flag_r && core_reset)
      else $error("brownout did not flag and reset");
   brown_off_lp_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_05]
      (ce && low_power(op_mode)) |=> !brown_fire)
      else $error("brownout detector on in low power");
   cause_zero_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_10]
      (rd_en && paddr == `MRC_OFF_CAUSE) |-> prdata[31:3] == 29'h0 && !prdata[1])
      else $error("unimplemented cause bits nonzero");
   soft_reset_a: assert property (@(posedge clk) disable iff (rst || !ce)  // [RULE_18]
      soft_launch_s |=> st_r == MRC_ST_SOFT)
      else $error("bad enable pattern ignored");
   wdc_flag_a: assert property (@(posedge clk) disable iff (rst || !ce)  // [RULE_09]
      soft_done |=> wdc_flag_r && core_reset)
      else $error("soft reset flag not set");
   warm_flags_a: assert property (@(posedge clk) disable iff (rst || !ce)  // [RULE_12]
      (st_r == MRC_ST_RUN && !brown_fire && wdog_timeout && low_power(op_mode))
      |=> warm_reset && to_flag_r && pdf_flag_r ##1 !warm_reset)
      else $error("low power expiry wrong");
   normal_to_a: assert property (@(posedge clk) disable iff (rst || !ce)  // [RULE_11]
      (st_r == MRC_ST_RUN && !brown_fire && wdog_timeout && !low_power(op_mode) && !halt_entry
       && !wdog_clear) |=> to_flag_r && core_reset && $stable(pdf_flag_r))
      else $error("normal expiry wrong");

endmodule

// File: verification/tb_mcu_reset_control.sv
// testbench for the reset control block: apb register access plus reset sources
// assumes the design's own assertions guard timing; bench checks register values
`timescale 1ns/1ps
`include "mrc_consts.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_mcu_reset_control;
   import mrc_pkg::*;

   // ---------------------------------------------
   // stimulus and observation
   // ---------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [1:0] op_mode = 2'h0;
   logic low_supply = 1'b0;
   logic wdog_timeout = 1'b0;
   logic wdog_clear = 1'b0;
   logic halt_entry = 1'b0;
   logic core_reset, warm_reset, irq_disable, timers_off, wdog_count_clear;
   logic [7:0] port_data_init, port_dir_init;
   logic [11:0] pc_init;
   logic [2:0] sp_init;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;

   always #25 clk = ~clk;

   // small counts keep the run short
   mrc_reset_ctrl #(.POR_CYCLES(4), .BROWNOUT_CYCLES(8), .SOFT_CYCLES(8)) i_mrc_reset_ctrl (
      .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_mode(op_mode), .low_supply(low_supply), .wdog_timeout(wdog_timeout),
      .wdog_clear(wdog_clear), .halt_entry(halt_entry), .core_reset(core_reset),
      .warm_reset(warm_reset), .port_data_init(port_data_init), .port_dir_init(port_dir_init),
      .pc_init(pc_init), .sp_init(sp_init), .irq_disable(irq_disable), .timers_off(timers_off),
      .wdog_count_clear(wdog_count_clear));

   // ---------------------------------------------
   // closing and hang guard
   // ---------------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("MISMATCH t=%0t run did not finish", $time);
         results();
      end
   end

   // ---------------------------------------------
   // apb master and helpers
   // ---------------------------------------------
   // idle cycle at the end so a following call never redrives psel in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // pready ends this wait; no local limit, only the bench's own cycle ceiling stops a hang
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   // masked read compare; bits outside the mask may be unknown
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(q & m, exp)
      `CHK(e, 1'b0)
   endtask

   task automatic wait_core(input logic lvl, input int lim);
      n = 0;
      while (core_reset !== lvl && n < lim) begin
         n++;
         @(posedge clk);
      end
      `CHK(core_reset, lvl)
   endtask

   task automatic quiet(input int len);
      repeat (len) begin
         @(posedge clk);
         `CHK(core_reset, 1'b0)
      end
   endtask

   task automatic pulse_halt();
      halt_entry <= 1'b1;
      @(posedge clk);
      halt_entry <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_clear();
      wdog_clear <= 1'b1;
      @(posedge clk);
      wdog_clear <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_timeout();
      wdog_timeout <= 1'b1;
      @(posedge clk);
      wdog_timeout <= 1'b0;
      @(posedge clk);
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK(core_reset, 1'b1)
      `CHK({irq_disable, timers_off, wdog_count_clear}, 3'h7)
      `CHK({port_data_init, port_dir_init}, 16'hFFFF)
      `CHK(pc_init, 12'h000)
      `CHK(sp_init, 3'h0)
      n = 1;
      while (core_reset === 1'b1 && n < 40) begin
         n++;
         @(posedge clk);
      end
      `CHK(n >= 4, 1'b1)
      wait_core(1'b0, 1);
      `CHK({irq_disable, timers_off, wdog_count_clear}, 3'h0)
      rd(`MRC_OFF_CAUSE, 32'hFFFF_FFFB, 32'h0);
      rd(`MRC_OFF_STATUS, 32'h3, 32'h0);
      rd(`MRC_OFF_WDOG_CTRL, 32'hFF, 32'h53);
      apb(1'b0, 12'h010, 32'h0, q, e);
      `CHK({e, q}, {1'b1, 32'h0})
      // software owns the cause flags; unimplemented bits stay zero
      wr(`MRC_OFF_CAUSE, 32'hFFFF_FFFF);
      rd(`MRC_OFF_CAUSE, 32'hFFFF_FFFF, 32'h5);
      wr(`MRC_OFF_CAUSE, 32'h0);
      rd(`MRC_OFF_CAUSE, 32'hFFFF_FFFF, 32'h0);
      // brief dip below the filter time
      low_supply <= 1'b1;
      repeat (4) @(posedge clk);
      low_supply <= 1'b0;
      quiet(15);
      // long dip while idle: detector off
      op_mode <= 2'h2;
      low_supply <= 1'b1;
      quiet(30);
      low_supply <= 1'b0;
      op_mode <= 2'h1;
      @(posedge clk);
      pulse_halt();
      rd(`MRC_OFF_STATUS, 32'h3, 32'h1);
      low_supply <= 1'b1;
      wait_core(1'b1, 30);
      low_supply <= 1'b0;
      wait_core(1'b0, 40);
      rd(`MRC_OFF_CAUSE, 32'hFF, 32'h4);
      rd(`MRC_OFF_STATUS, 32'h3, 32'h1);
      pulse_clear();
      op_mode <= 2'h0;
      // normal-mode expiry keeps the power-down flag
      pulse_halt();
      pulse_timeout();
      `CHK(core_reset, 1'b1)
      wait_core(1'b0, 40);
      rd(`MRC_OFF_STATUS, 32'h3, 32'h3);
      pulse_clear();
      rd(`MRC_OFF_STATUS, 32'h3, 32'h0);
      // expiry while asleep gives a warm reset that also clears the watchdog count, no core reset
      pulse_halt();
      op_mode <= 2'h3;
      wdog_timeout <= 1'b1;
      @(posedge clk);
      wdog_timeout <= 1'b0;
      @(posedge clk);
      `CHK({warm_reset, core_reset, wdog_count_clear}, 3'h5)
      @(posedge clk);
      `CHK(warm_reset, 1'b0)
      rd(`MRC_OFF_STATUS, 32'h3, 32'h3);
      op_mode <= 2'h0;
      pulse_clear();
      // both enable patterns run on, anything else restarts
      wr(`MRC_OFF_WDOG_CTRL, 32'hAB);
      quiet(20);
      rd(`MRC_OFF_WDOG_CTRL, 32'hFF, 32'hAB);
      wr(`MRC_OFF_WDOG_CTRL, 32'h53);
      quiet(20);
      wr(`MRC_OFF_WDOG_CTRL, 32'h0B);
      wait_core(1'b1, 40);
      wait_core(1'b0, 40);
      rd(`MRC_OFF_CAUSE, 32'hFF, 32'h5);
      rd(`MRC_OFF_WDOG_CTRL, 32'hFF, 32'h53);
      wr(`MRC_OFF_CAUSE, 32'h0);
      rd(`MRC_OFF_CAUSE, 32'hFF, 32'h0);
      // a low enable freezes all state, so a time-out pulse in that window is lost
      ce <= 1'b0;
      pulse_timeout();
      ce <= 1'b1;
      quiet(3);
      rd(`MRC_OFF_STATUS, 32'h3, 32'h0);
      results();
   end

endmodule
